// *** src/alcx_level_ctrl.sv ***
// Purpose: automatic level control of a shared stereo input gain
// Assumes: samples arrive post-gain, strobed by sample_valid_i on clk_i
// Notes: registers over Avalon-MM, one wait state per access
//
// Behaviour
// - level control runs only when enabled
// - playback path only when recording converters off
// - over detection lowers both gains together
// - threshold field picks detection level and band
// - limiter changes at zero crossing or timeout
// - timeout field 128..1024 samples, shared use
// - zero-cross disabled: immediate change, one step
// - attenuation field picks 1,2,4,8 steps
// - attenuate until level drops, retrigger later
// - wait period then recover if band clean
// - recovery raises both gains 1..4 steps
// - recovery never exceeds the gain ceiling
// - band level resets wait, below runs it
// - one recovery step per wait period
// - impulse noise gives 4,8,16 times recovery
// - manual gain writes deferred while running
// - start from left gain, no clamp on start

`timescale 1ns/1ps
`default_nettype none

module alcx_level_ctrl
	import alcx_pkg::*;
#(
	parameter int TMO_BASE = ALCX_TMO_BASE,
	parameter int WAIT_BASE = ALCX_WAIT_BASE
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// avalon-mm slave
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// post-gain sample stream
	input wire logic sample_valid_i,
	input wire logic signed [15:0] left_sample_i,
	input wire logic signed [15:0] right_sample_i,
	// gain codes to the input gain stage
	output logic [7:0] left_input_gain_o,
	output logic [7:0] right_input_gain_o,
	output logic alc_active_o,
	output logic path_playback_o
);

	// elaboration checks of the scaling parameters
	if (TMO_BASE < 1 || TMO_BASE > 128 || (TMO_BASE & (TMO_BASE - 1)) != 0) begin : g_bad_tmo
		$error("TMO_BASE must be a power of two up to 128");
	end
	if (WAIT_BASE < 16 || WAIT_BASE > 128 || (WAIT_BASE & (WAIT_BASE - 1)) != 0) begin : g_bad_wait
		$error("WAIT_BASE must be a power of two from 16 to 128");
	end

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	logic [31:0] ctrl_q;
	logic [7:0] ceil_q;
	logic [7:0] man_gain_q [2];
	logic ack_q;
	logic [31:0] rdata_q;
	logic [7:0] gain_q [2];
	alcx_state_t state_q;
	logic impulse_q;

	// one wait state; access completes when ack_q is high
	wire bus_req = avs_read_i | avs_write_i;
	wire bus_wr = avs_write_i & ack_q;
	wire [31:0] be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
		{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	wire [31:0] ctrl_wr = ((ctrl_q & ~be_mask) | (avs_writedata_i & be_mask)) & {13'h0, ALCX_CTRL_MASK};
	wire hit_ctrl = avs_address_i == ALCX_OFS_CTRL;
	wire hit_ceil = avs_address_i == ALCX_OFS_CEIL;
	wire hit_lg = avs_address_i == ALCX_OFS_LGAIN;
	wire hit_rg = avs_address_i == ALCX_OFS_RGAIN;
	wire hit_stat = avs_address_i == ALCX_OFS_STAT;
	wire [31:0] stat_word = {12'h0, impulse_q, path_playback_o, state_q, gain_q[1], gain_q[0]};
	wire [31:0] rd_mux = hit_ctrl ? ctrl_q :
		hit_ceil ? {24'h0, ceil_q} :
		hit_lg ? {24'h0, man_gain_q[0]} :
		hit_rg ? {24'h0, man_gain_q[1]} :
		hit_stat ? stat_word : 32'h0000_0000;

	assign avs_waitrequest_o = bus_req & ~ack_q;
	assign avs_readdata_o = rdata_q;

	// handshake and read data capture
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= bus_req & ~ack_q;
			if (avs_read_i & ~ack_q)
				rdata_q <= rd_mux;
		end
	end

	// writable registers; manual gains always stored, used only when idle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_q <= ALCX_CTRL_RST;
			ceil_q <= ALCX_CEIL_RST;
			man_gain_q[0] <= ALCX_GAIN_RST;
			man_gain_q[1] <= ALCX_GAIN_RST;
		end else if (bus_wr) begin
			if (hit_ctrl)
				ctrl_q <= ctrl_wr;
			if (hit_ceil && avs_byteenable_i[0])
				ceil_q <= avs_writedata_i[7:0];
			if (hit_lg && avs_byteenable_i[0])
				man_gain_q[0] <= avs_writedata_i[7:0];
			if (hit_rg && avs_byteenable_i[0])
				man_gain_q[1] <= avs_writedata_i[7:0];
		end
	end

	// ----------------------------------------------------------------
	// settings decode
	// ----------------------------------------------------------------
	wire en = ctrl_q[ALCX_B_EN];
	wire zcd = ctrl_q[ALCX_B_ZCD];
	wire [1:0] tmo_sel = ctrl_q[ALCX_F_TMO +: 2];
	wire [1:0] thr_sel = ctrl_q[ALCX_F_THR +: 2];
	wire [1:0] att_sel = ctrl_q[ALCX_F_ATT +: 2];
	wire [2:0] wait_sel = ctrl_q[ALCX_F_WAIT +: 3];
	wire [1:0] rstep_sel = ctrl_q[ALCX_F_RSTEP +: 2];
	wire [1:0] fast_sel = ctrl_q[ALCX_F_FAST +: 2];

	// path selection from converter power
	wire rec_path = ctrl_q[ALCX_B_PWR_L] | ctrl_q[ALCX_B_PWR_R];
	wire play_path = ~rec_path & ctrl_q[ALCX_B_PWR_DAC];
	wire run = en & (rec_path | play_path);

	// detection level and lower edge of reset band
	wire [15:0] det_lvl = thr_sel == 2'd0 ? ALCX_LVL_2P5 :
		thr_sel == 2'd1 ? ALCX_LVL_4P1 :
		thr_sel == 2'd2 ? ALCX_LVL_6P0 : ALCX_LVL_8P5;
	wire [15:0] band_lvl = thr_sel == 2'd0 ? ALCX_LVL_4P1 :
		thr_sel == 2'd1 ? ALCX_LVL_6P0 :
		thr_sel == 2'd2 ? ALCX_LVL_8P5 : ALCX_LVL_12;

	// step sizes: zero-cross disable forces a single attenuation step
	wire [7:0] att_step = zcd ? 8'h01 : 8'(8'h01 << att_sel);
	wire [7:0] rec_step = 8'({6'h0, rstep_sel} + 8'h01);

	// shared timeout and wait lengths in samples
	wire [15:0] tmo_len = 16'(TMO_BASE << tmo_sel);
	wire [3:0] fast_shift = 4'(ALCX_FAST_SHIFT_MIN) + (fast_sel == 2'd3 ? 4'h0 : {2'h0, fast_sel});
	wire [15:0] wait_full = 16'(WAIT_BASE << wait_sel);
	wire [15:0] wait_len = impulse_q ? (wait_full >> fast_shift) : wait_full;

	// ----------------------------------------------------------------
	// per-channel level and zero crossing
	// ----------------------------------------------------------------
	logic [1:0] over;
	logic [1:0] in_band;
	logic [1:0] zc;
	logic prev_neg_q [2];
	wire signed [15:0] samp [2];
	assign samp[0] = left_sample_i;
	assign samp[1] = right_sample_i;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_chan
			wire [15:0] mag = samp[ch][15] ? ((samp[ch] == 16'sh8000) ? 16'h7FFF : 16'(-samp[ch]))
				: samp[ch];
			assign over[ch] = mag >= det_lvl;
			assign in_band[ch] = ~over[ch] & (mag >= band_lvl);
			// sign change or exact zero counts as a crossing
			assign zc[ch] = (samp[ch][15] != prev_neg_q[ch]) | (samp[ch] == 16'sh0000);
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i)
					prev_neg_q[ch] <= 1'b0;
				else if (sample_valid_i)
					prev_neg_q[ch] <= samp[ch][15];
			end
		end
	endgenerate

	wire any_over = |over;
	wire any_band = |in_band;
	wire all_below = ~any_over & ~any_band;

	// ----------------------------------------------------------------
	// gain update at zero crossing or timeout
	// ----------------------------------------------------------------
	logic [7:0] target_q;
	logic [15:0] tmo_cnt_q;
	logic [1:0] pend;
	logic [1:0] apply;
	wire tmo_hit = tmo_cnt_q >= tmo_len - 16'h0001;
	wire imm = zcd & (state_q == ALCX_LIMIT);
	wire pending = |pend;

	generate
		for (ch = 0; ch < 2; ch++) begin : g_gain
			wire [7:0] want = state_q == ALCX_OFF ? man_gain_q[ch] : target_q;
			assign pend[ch] = gain_q[ch] != want;
			assign apply[ch] = sample_valid_i & pend[ch] & (zc[ch] | tmo_hit | imm);
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i)
					gain_q[ch] <= ALCX_GAIN_RST;
				else if (apply[ch])
					gain_q[ch] <= want;
			end
		end
	endgenerate

	// timeout counter runs only while a change waits
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			tmo_cnt_q <= 16'h0000;
		else if (!pending || (sample_valid_i && tmo_hit))
			tmo_cnt_q <= 16'h0000;
		else if (sample_valid_i)
			tmo_cnt_q <= tmo_cnt_q + 16'h0001;
	end

	// ----------------------------------------------------------------
	// limiter and recovery sequencing
	// ----------------------------------------------------------------
	alcx_state_t next_state;
	logic [7:0] next_target;
	logic [15:0] wait_cnt_q;
	logic [15:0] next_wait;
	logic next_imp;
	logic below_prev_q;
	wire [8:0] rec_sum = {1'b0, target_q} + {1'b0, rec_step};
	wire [7:0] rec_val = rec_sum > {1'b0, ceil_q} ? ceil_q : rec_sum[7:0];
	wire [7:0] att_val = target_q == ALCX_GAIN_MUTE ? ALCX_GAIN_MUTE :
		target_q <= att_step ? ALCX_GAIN_MIN : target_q - att_step;
	wire wait_done = wait_cnt_q >= wait_len - 16'h0001;

	// next state of the level loop, evaluated per sample
	always_comb begin
		next_state = state_q;
		next_target = target_q;
		next_wait = wait_cnt_q;
		next_imp = impulse_q;
		if (!run) begin
			next_state = ALCX_OFF;
			next_imp = 1'b0;
		end else if (state_q == ALCX_OFF) begin
			next_state = ALCX_TRACK;
			next_target = gain_q[0];
			next_wait = 16'h0000;
		end else if (any_over) begin
			next_wait = 16'h0000;
			if (!pending) begin
				next_target = att_val;
				next_state = ALCX_LIMIT;
				next_imp = below_prev_q;
			end
		end else if (state_q == ALCX_LIMIT) begin
			next_wait = 16'h0000;
			if (!pending)
				next_state = ALCX_TRACK;
		end else if (any_band) begin
			next_wait = 16'h0000;
		end else if (all_below) begin
			if (!pending && state_q == ALCX_RECOVER)
				next_state = ALCX_TRACK;
			if (wait_done) begin
				next_wait = 16'h0000;
				if (!pending && target_q < ceil_q) begin
					next_target = rec_val;
					next_state = ALCX_RECOVER;
				end
				if (target_q >= ceil_q)
					next_imp = 1'b0;
			end else begin
				next_wait = wait_cnt_q + 16'h0001;
			end
		end
	end

	// loop state registers advance once per sample
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ALCX_OFF;
			target_q <= ALCX_GAIN_RST;
			wait_cnt_q <= 16'h0000;
			impulse_q <= 1'b0;
			below_prev_q <= 1'b1;
		end else if (sample_valid_i) begin
			state_q <= next_state;
			target_q <= next_target;
			wait_cnt_q <= next_wait;
			impulse_q <= next_imp;
			below_prev_q <= all_below;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign left_input_gain_o = gain_q[0];
	assign right_input_gain_o = gain_q[1];
	assign alc_active_o = state_q != ALCX_OFF;
	assign path_playback_o = play_path;

endmodule

`default_nettype wire

// *** src/alcx_pkg.sv ***
// Purpose: shared constants and types of the stereo level control block
// Assumes: 16-bit two's complement samples, one sample strobe per fs
// Notes: gain codes 0xF1 = +36 dB down to 0x01 = -54 dB, 0x00 = mute

package alcx_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ALCX_OFS_CTRL = 8'h00;
	localparam logic [7:0] ALCX_OFS_CEIL = 8'h04;
	localparam logic [7:0] ALCX_OFS_LGAIN = 8'h08;
	localparam logic [7:0] ALCX_OFS_RGAIN = 8'h0C;
	localparam logic [7:0] ALCX_OFS_STAT = 8'h10;

	// ----------------------------------------------------------------
	// control register fields
	// ----------------------------------------------------------------
	localparam int ALCX_B_EN = 0;
	localparam int ALCX_B_ZCD = 1;
	localparam int ALCX_F_TMO = 2;
	localparam int ALCX_F_THR = 4;
	localparam int ALCX_F_ATT = 6;
	localparam int ALCX_F_WAIT = 8;
	localparam int ALCX_F_RSTEP = 11;
	localparam int ALCX_F_FAST = 13;
	localparam int ALCX_B_PWR_L = 16;
	localparam int ALCX_B_PWR_R = 17;
	localparam int ALCX_B_PWR_DAC = 18;
	localparam logic [18:0] ALCX_CTRL_MASK = 19'h7_7FFF;
	localparam logic [31:0] ALCX_CTRL_RST = 32'h0000_0000;

	// ----------------------------------------------------------------
	// status register fields
	// ----------------------------------------------------------------
	localparam int ALCX_S_LGAIN = 0;
	localparam int ALCX_S_RGAIN = 8;
	localparam int ALCX_S_STATE = 16;
	localparam int ALCX_S_PLAY = 18;
	localparam int ALCX_S_IMP = 19;

	// ----------------------------------------------------------------
	// gain codes and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ALCX_GAIN_MUTE = 8'h00;
	localparam logic [7:0] ALCX_GAIN_MIN = 8'h01;
	localparam logic [7:0] ALCX_GAIN_MAX = 8'hF1;
	localparam logic [7:0] ALCX_CEIL_RST = 8'hE1;
	localparam logic [7:0] ALCX_GAIN_RST = 8'hE1;

	// ----------------------------------------------------------------
	// magnitude thresholds, 16-bit full scale
	// ----------------------------------------------------------------
	localparam logic [15:0] ALCX_LVL_2P5 = 16'h5FFD;  // -2.5 dBFS
	localparam logic [15:0] ALCX_LVL_4P1 = 16'h4FD5;  // -4.1 dBFS
	localparam logic [15:0] ALCX_LVL_6P0 = 16'h4026;  // -6.0 dBFS
	localparam logic [15:0] ALCX_LVL_8P5 = 16'h301A;  // -8.5 dBFS
	localparam logic [15:0] ALCX_LVL_12 = 16'h2027;  // -12 dBFS

	// ----------------------------------------------------------------
	// timing, in sample periods
	// ----------------------------------------------------------------
	localparam int ALCX_TMO_BASE = 128;
	localparam int ALCX_WAIT_BASE = 128;
	localparam int ALCX_FAST_SHIFT_MIN = 2;

	// ----------------------------------------------------------------
	// level control state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ALCX_OFF = 2'b00,
		ALCX_TRACK = 2'b01,
		ALCX_LIMIT = 2'b11,
		ALCX_RECOVER = 2'b10
	} alcx_state_t;

endpackage

// *** verification/alcx_level_ctrl_asserts.sv ***
// Purpose: port-level checks of the stereo level control block
// Assumes: one clock, asynchronous active-low reset
// Notes: enable and power bits are shadowed from completed bus writes

`timescale 1ns/1ps
`default_nettype none

module alcx_level_ctrl_asserts
	import alcx_pkg::*;
#(
	parameter int TMO_BASE = ALCX_TMO_BASE,
	parameter int WAIT_BASE = ALCX_WAIT_BASE
) (
	// clock, reset and bus
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	// stream and gains
	input wire logic sample_valid_i,
	input wire logic signed [15:0] left_sample_i,
	input wire logic signed [15:0] right_sample_i,
	input wire logic [7:0] left_input_gain_o,
	input wire logic [7:0] right_input_gain_o,
	input wire logic alc_active_o,
	input wire logic path_playback_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	logic [2:0] pwr;
	logic en;
	wire logic ctrl_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == ALCX_OFS_CTRL;

	// shadow of enable and converter power bits
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pwr <= 3'h0;
			en <= 1'b0;
		end else if (ctrl_wr) begin
			if (avs_byteenable_i[2]) pwr <= avs_writedata_i[18:16];
			if (avs_byteenable_i[0]) en <= avs_writedata_i[0];
		end
	end

	property p_wait_one;
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait state longer than one cycle");
	property p_idle_ready;
		!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o;
	endproperty
	a_idle_ready: assert property (p_idle_ready) else $error("waitrequest high without request");
	property p_rdata_hold;
		$changed(avs_readdata_o) |-> $past(avs_read_i);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
	property p_gain_strobe;
		$changed(left_input_gain_o) || $changed(right_input_gain_o) |-> $past(sample_valid_i);
	endproperty
	a_gain_strobe: assert property (p_gain_strobe) else $error("gain moved off a sample strobe");
	property p_gain_max;
		left_input_gain_o <= ALCX_GAIN_MAX && right_input_gain_o <= ALCX_GAIN_MAX;
	endproperty
	a_gain_max: assert property (p_gain_max) else $error("gain code above top code");
	property p_att_bound;
		alc_active_o && $past(alc_active_o) && left_input_gain_o < $past(left_input_gain_o) |->
			$past(left_input_gain_o) - left_input_gain_o <= 8'h08 && left_input_gain_o != ALCX_GAIN_MUTE;
	endproperty
	a_att_bound: assert property (p_att_bound) else $error("attenuation step too large or muted");
	property p_rec_bound;
		alc_active_o && $past(alc_active_o) && left_input_gain_o > $past(left_input_gain_o) |->
			left_input_gain_o - $past(left_input_gain_o) <= 8'h04;
	endproperty
	a_rec_bound: assert property (p_rec_bound) else $error("recovery step too large");
	property p_path;
		path_playback_o == (pwr == 3'h4);
	endproperty
	a_path: assert property (p_path) else $error("path select wrong for power bits");
	property p_active_en;
		$rose(alc_active_o) |-> en;
	endproperty
	a_active_en: assert property (p_active_en) else $error("loop started while disabled");
endmodule

`default_nettype wire

// *** verification/alcx_level_ctrl_tb.sv ***
// Purpose: self-checking bench of the level control block
// Assumes: shortened timeout and wait bases
// Notes: bus tasks hold each request until waitrequest is seen low

`timescale 1ns/1ps
`default_nettype none

module alcx_level_ctrl_tb;
	import alcx_pkg::*;
	localparam int TMO_B = 4;
	localparam int WAIT_B = 16;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] avs_address_i = 8'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0000_0000;
	logic [3:0] avs_byteenable_i = 4'h0;
	logic [15:0] amp = 16'h0000;
	logic [31:0] avs_readdata_o, q;
	logic avs_waitrequest_o, sample_valid_i, alc_active_o, path_playback_o;
	logic signed [15:0] left_sample_i, right_sample_i;
	logic [7:0] left_input_gain_o, right_input_gain_o, g;
	int n_errors = 0;
	int total_checks = 0;

	always #2.5 clk_i = !clk_i;

	alcx_level_ctrl #(.TMO_BASE(TMO_B), .WAIT_BASE(WAIT_B)) alcx_level_ctrl_inst (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .sample_valid_i(sample_valid_i), .left_sample_i(left_sample_i),
		.right_sample_i(right_sample_i), .left_input_gain_o(left_input_gain_o),
		.right_input_gain_o(right_input_gain_o), .alc_active_o(alc_active_o), .path_playback_o(path_playback_o));
	alcx_src_model alcx_src_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .amp_i(amp),
		.sample_valid_o(sample_valid_i), .left_o(left_sample_i), .right_o(right_sample_i));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_byteenable_i <= 4'hF;
		avs_read_i <= !wr;
		avs_write_i <= wr;
		// hold until waitrequest is sampled low at a rising edge
		do begin
			@(posedge clk_i);
		end while (avs_waitrequest_o !== 1'b0);
		r = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		// let the edge's register updates settle before callers look
		@(negedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000, q);
		chk(q, e);
	endtask
	task automatic strobes(input int n);
		repeat (n * 4) @(posedge clk_i);
		@(negedge clk_i);
	endtask
	task automatic level(input logic [15:0] a);
		@(posedge clk_i);
		amp <= a;
	endtask
	task automatic gains(input logic [7:0] l, input logic [7:0] r);
		chk(left_input_gain_o, l);
		chk(right_input_gain_o, r);
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		gains(ALCX_GAIN_RST, ALCX_GAIN_RST);
		rd_chk(ALCX_OFS_CTRL, ALCX_CTRL_RST);
		rd_chk(ALCX_OFS_CEIL, {24'h00_0000, ALCX_CEIL_RST});
		rd_chk(8'h14, 32'h0000_0000);
		wr(ALCX_OFS_CTRL, 32'hFFFF_FFFF);
		rd_chk(ALCX_OFS_CTRL, {13'h0000, ALCX_CTRL_MASK});
		for (int i = 0; i < 8; i++) begin
			wr(ALCX_OFS_CTRL, {13'h0000, i[2:0], 16'h0000});
			chk(path_playback_o, i == 4);
		end
		wr(ALCX_OFS_CTRL, 32'h0001_0000);
		wr(ALCX_OFS_LGAIN, 32'h0000_0091);
		wr(ALCX_OFS_RGAIN, 32'h0000_0080);
		wr(ALCX_OFS_CEIL, 32'h0000_0095);
		level(16'h0100);
		strobes(20);
		gains(8'h91, 8'h80);
		wr(ALCX_OFS_CTRL, 32'h0001_1803);
		strobes(200);
		gains(8'h95, 8'h95);
		wr(ALCX_OFS_LGAIN, 32'h0000_0070);
		level(16'h7000);
		strobes(6);
		level(16'h5800);
		strobes(4);
		g = left_input_gain_o;
		chk(right_input_gain_o, g);
		chk(g inside {[8'h8E:8'h93]}, 1);
		strobes(200);
		gains(g, g);
		level(16'h0100);
		strobes(400);
		gains(8'h95, 8'h95);
		bus(1'b0, ALCX_OFS_STAT, 32'h0000_0000, q);
		chk(q[15:0], 16'h9595);
		wr(ALCX_OFS_CTRL, 32'h0001_0000);
		strobes(20);
		gains(8'h70, 8'h80);
		chk(alc_active_o, 1'b0);
		// playback path, zero-cross timing, 8-step attenuation, 8x fast recovery
		wr(ALCX_OFS_CTRL, 32'h0004_21F5);
		chk(path_playback_o, 1'b1);
		strobes(8);
		gains(8'h70, 8'h70);
		chk(alc_active_o, 1'b1);
		// one short burst over the lowest threshold gives a single impulse event
		level(16'h3800);
		strobes(1);
		level(16'h0100);
		strobes(12);
		gains(8'h6A, 8'h6A);
		wr(ALCX_OFS_CTRL, 32'h0004_0000);
		strobes(8);
		gains(8'h70, 8'h80);
		chk(alc_active_o, 1'b0);
		close_out();
	end
	initial begin
		#100000;
		n_errors++;
		close_out();
	end
endmodule

bind alcx_level_ctrl alcx_level_ctrl_asserts #(.TMO_BASE(TMO_BASE), .WAIT_BASE(WAIT_BASE)) alcx_level_ctrl_asserts_inst (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .sample_valid_i(sample_valid_i),
	.left_sample_i(left_sample_i), .right_sample_i(right_sample_i), .left_input_gain_o(left_input_gain_o),
	.right_input_gain_o(right_input_gain_o), .alc_active_o(alc_active_o), .path_playback_o(path_playback_o));

`default_nettype wire

// *** verification/alcx_src_model.sv ***
// Purpose: converter-side sample source for the level control bench
// Assumes: strobe every fourth clock, bench sets the magnitude
// Notes: sign flips every sample, so each sample is a zero crossing

`timescale 1ns/1ps
`default_nettype none

module alcx_src_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// magnitude from the bench
	input wire logic [15:0] amp_i,
	// sample stream
	output logic sample_valid_o,
	output logic signed [15:0] left_o,
	output logic signed [15:0] right_o
);
	logic [1:0] div;
	logic neg;
	logic signed [15:0] val;

	// strobe divider and sign toggle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div <= 2'h0;
			neg <= 1'b0;
		end else begin
			div <= div + 2'h1;
			if (div == 2'h3) neg <= !neg;
		end
	end

	// off-strobe the lines carry the inverted upcoming sample
	assign val = neg ? -$signed(amp_i) : $signed(amp_i);
	assign sample_valid_o = rst_n_i && div == 2'h3;
	assign left_o = sample_valid_o ? val : ~val;
	assign right_o = sample_valid_o ? val : ~val;
endmodule

`default_nettype wire
